// *** hw/bridge_general_ctl.sv ***
// Subsystem identifier alias and upper general control register bank.
// Assumes configuration accesses arrive as one-cycle strobes on i_clock;
// link reset and global reset pin are asynchronous levels, synchronised here.
// What this block does
// - Writing the alias upper half-word updates the product identifier seen at 46h.
// - Writing the alias lower half-word updates the maker identifier seen at 44h.
// - Retry window select picks 25 us, 1 ms, 25 ms or 50 ms of secondary retries.
// - Link power default select gives the power-up value of link control bits 1:0.
// - Transmitter low-power bit selects half amplitude without pre-emphasis.
// - Revision select reports version 010b/no-soft-reset 0 or 011b/1.
// - Bit 24 is read-only and reads zero.
// - Clock power default bit yields 00b or 11b for link control clock enable.
// - Writable fields return to defaults on link, global or power-on reset.
`timescale 1ns/1ps
`default_nettype none
module bridge_general_ctl (
   // Clock and resets
   input  wire logic        i_clock,
   input  wire logic        i_resetn,
   input  wire logic        i_link_resetn,
   input  wire logic        i_global_reset_pin_n,
   // Configuration access
   input  wire logic        i_cfg_wr,
   input  wire logic        i_cfg_rd,
   input  wire logic [7:0]  i_cfg_addr,
   input  wire logic [3:0]  i_cfg_be,
   input  wire logic [31:0] i_cfg_wdata,
   output logic      [31:0] o_cfg_rdata,
   output logic             o_cfg_hit,
   // Configuration retry timing
   input  wire logic        i_retry_start,
   output logic             o_retry_expired,
   // Derived controls
   output logic      [1:0]  o_link_pm_default,
   output logic      [1:0]  o_clock_pm_enable_field,
   output logic             o_tx_low_power,
   output logic      [2:0]  o_pm_revision_field,
   output logic             o_no_soft_reset
);
   logic [1:0]  lrst_sync_r;
   logic [1:0]  global_reset_pin_sync_r;
   logic        cfg_reset;
   logic [31:0] ident;
   logic [31:0] gen_r;
   logic [31:0] gen_nxt;
   logic [31:0] gen_read;
   logic [31:0] rdata_r;
   logic [23:0] retry_cnt_r;
   logic        retry_busy_r;
   logic        expired_r;
   logic [23:0] retry_limit;
   logic        hit_alias;
   logic        hit_gen;
   logic        hit_vendor;
   logic        hit_product;
   logic [31:0] wmask;

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // Pins pass two flops before use
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         lrst_sync_r <= 2'b00;
         global_reset_pin_sync_r <= 2'b00;
      end else begin
         lrst_sync_r <= {lrst_sync_r[0], i_link_resetn};
         global_reset_pin_sync_r <= {global_reset_pin_sync_r[0], i_global_reset_pin_n};
      end
   end
   assign cfg_reset = !lrst_sync_r[1] || !global_reset_pin_sync_r[1];

   assign hit_alias   = (i_cfg_addr == bridge_ctl_pkg::OFF_ALIAS);
   assign hit_gen     = (i_cfg_addr == bridge_ctl_pkg::OFF_GEN_CTRL);
   assign hit_vendor  = (i_cfg_addr == bridge_ctl_pkg::OFF_SUBSYS_VENDOR);
   assign hit_product = (i_cfg_addr == bridge_ctl_pkg::OFF_SUBSYS_PRODUCT);

   // Only the alias writes the identifiers; 44h/46h stay read-only views
   ident_store u_ident (
      .i_clock     (i_clock),
      .i_resetn    (i_resetn),
      .i_cfg_reset (cfg_reset),
      .i_wr        (i_cfg_wr && hit_alias),
      .i_be        (i_cfg_be),
      .i_wdata     (i_cfg_wdata),
      .o_value     (ident)
   );

   // Bits 22:0 belong elsewhere; they hold reset values here
   assign wmask   = lane_mask(i_cfg_be) & bridge_ctl_pkg::GEN_CTRL_WMASK;
   assign gen_nxt = (i_cfg_wr && hit_gen) ? ((gen_r & ~wmask) | (i_cfg_wdata & wmask)) : gen_r;
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         gen_r <= bridge_ctl_pkg::GEN_CTRL_RESET;
      end else if (cfg_reset) begin
         gen_r <= bridge_ctl_pkg::GEN_CTRL_RESET;
      end else begin
         gen_r <= gen_nxt;
      end
   end
   assign gen_read = {gen_r[31:25], 1'b0, gen_r[23:0]};

   // Views at 44h (whole word) and 46h (upper half-word, zero-extended) read the same storage as the alias
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_r <= 32'h0000_0000;
      end else if (i_cfg_rd) begin
         rdata_r <= hit_alias   ? ident :
                    hit_gen     ? gen_read :
                    hit_vendor  ? {ident[31:16], ident[15:0]} :
                    hit_product ? {16'h0000, ident[31:16]} : 32'h0000_0000;
      end
   end
   assign o_cfg_rdata = rdata_r;
   assign o_cfg_hit   = hit_alias || hit_gen || hit_vendor || hit_product;

   // Retry window
   localparam int POS_RETRY_LO = bridge_ctl_pkg::POS_RETRY;
   localparam int POS_RETRY_HI = bridge_ctl_pkg::POS_RETRY + 1;
   assign retry_limit = (gen_r[POS_RETRY_HI:POS_RETRY_LO] == 2'b00) ? bridge_ctl_pkg::RETRY_CYC_0 :
                        (gen_r[POS_RETRY_HI:POS_RETRY_LO] == 2'b01) ? bridge_ctl_pkg::RETRY_CYC_1 :
                        (gen_r[POS_RETRY_HI:POS_RETRY_LO] == 2'b10) ? bridge_ctl_pkg::RETRY_CYC_2 :
                        bridge_ctl_pkg::RETRY_CYC_3;
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         retry_cnt_r  <= 24'h00_0000;
         retry_busy_r <= 1'b0;
         expired_r    <= 1'b0;
      end else begin
         expired_r <= 1'b0;
         if (i_retry_start) begin
            retry_cnt_r  <= 24'h00_0001;
            retry_busy_r <= 1'b1;
         end else if (retry_busy_r) begin
            if (retry_cnt_r >= retry_limit) begin
               retry_busy_r <= 1'b0;
               expired_r    <= 1'b1;
            end else begin
               retry_cnt_r <= retry_cnt_r + 24'h00_0001;
            end
         end
      end
   end
   assign o_retry_expired = expired_r;

   // Derived outputs straight from register flops
   assign o_link_pm_default       = gen_r[bridge_ctl_pkg::POS_LINK_PM +: 2];
   assign o_clock_pm_enable_field = {2{gen_r[bridge_ctl_pkg::POS_CLKPM]}};
   assign o_tx_low_power          = gen_r[bridge_ctl_pkg::POS_LOW_POWER];
   assign o_pm_revision_field     = gen_r[bridge_ctl_pkg::POS_PM_REV] ? bridge_ctl_pkg::PM_REV_NEW
                                                                      : bridge_ctl_pkg::PM_REV_OLD;
   assign o_no_soft_reset         = gen_r[bridge_ctl_pkg::POS_PM_REV];

   property p_ident_write;
      @(posedge i_clock) disable iff (!i_resetn)
      (i_cfg_wr && hit_alias && i_cfg_be == 4'hF && !cfg_reset) |=> (ident == $past(i_cfg_wdata));
   endproperty
   a_ident_write: assert property (p_ident_write) else $error("alias write lost");

   property p_product_view;
      @(posedge i_clock) disable iff (!i_resetn)
      (i_cfg_rd && hit_product) |=> (o_cfg_rdata[15:0] == $past(ident[31:16]));
   endproperty
   a_product_view: assert property (p_product_view) else $error("product view mismatch");

   property p_vendor_view;
      @(posedge i_clock) disable iff (!i_resetn)
      (i_cfg_rd && hit_vendor) |=> (o_cfg_rdata[15:0] == $past(ident[15:0]));
   endproperty
   a_vendor_view: assert property (p_vendor_view) else $error("vendor view mismatch");

   property p_bit24_zero;
      @(posedge i_clock) disable iff (!i_resetn)
      (i_cfg_rd && hit_gen) |=> (o_cfg_rdata[24] == 1'b0);
   endproperty
   a_bit24_zero: assert property (p_bit24_zero) else $error("bit 24 not zero");

   property p_cfg_reset_default;
      @(posedge i_clock) disable iff (!i_resetn)
      cfg_reset |=> (gen_r == bridge_ctl_pkg::GEN_CTRL_RESET && ident == bridge_ctl_pkg::ALIAS_RESET);
   endproperty
   a_cfg_reset_default: assert property (p_cfg_reset_default) else $error("defaults not restored");

   // Checked against the written bit, so a swapped mux or a stuck flag fires
   property p_pm_rev;
      @(posedge i_clock) disable iff (!i_resetn)
      (i_cfg_wr && hit_gen && i_cfg_be[3] && !cfg_reset) |=>
      (o_no_soft_reset == $past(i_cfg_wdata[26])) &&
      (o_pm_revision_field == ($past(i_cfg_wdata[26]) ? bridge_ctl_pkg::PM_REV_NEW : bridge_ctl_pkg::PM_REV_OLD));
   endproperty
   a_pm_rev: assert property (p_pm_rev) else $error("pm revision mismatch");

   property p_clkpm;
      @(posedge i_clock) disable iff (!i_resetn)
      (i_cfg_wr && hit_gen && i_cfg_be[2] && !cfg_reset) |=>
      (o_clock_pm_enable_field == {2{$past(i_cfg_wdata[23])}});
   endproperty
   a_clkpm: assert property (p_clkpm) else $error("clock pm field not taken");

   property p_retry_short;
      @(posedge i_clock) disable iff (!i_resetn)
      (i_retry_start && gen_r[POS_RETRY_HI:POS_RETRY_LO] == 2'b00 && !cfg_reset) ##1 (!i_retry_start)[*8]
      |-> !o_retry_expired;
   endproperty
   a_retry_short: assert property (p_retry_short) else $error("retry ended early");

   property p_low_power;
      @(posedge i_clock) disable iff (!i_resetn)
      (i_cfg_wr && hit_gen && i_cfg_be[3] && !cfg_reset) |=> (o_tx_low_power == $past(i_cfg_wdata[27]));
   endproperty
   a_low_power: assert property (p_low_power) else $error("low power bit not taken");
endmodule
`default_nettype wire

// *** hw/bridge_ctl_pkg.sv ***
// Constants for the subsystem alias and general control register bank.
// Assumes a single 200 MHz clock and byte-offset configuration addressing.
package bridge_ctl_pkg;
   localparam logic [7:0]  OFF_SUBSYS_VENDOR = 8'h44;
   localparam logic [7:0]  OFF_SUBSYS_PRODUCT = 8'h46;
   localparam logic [7:0]  OFF_ALIAS         = 8'hD0;
   localparam logic [7:0]  OFF_GEN_CTRL      = 8'hD4;
   localparam logic [31:0] ALIAS_RESET       = 32'h0000_0000;
   localparam logic [31:0] GEN_CTRL_RESET    = 32'h8600_025F;
   localparam logic [31:0] GEN_CTRL_WMASK    = 32'hFE80_0000;
   localparam int          POS_RETRY         = 30;
   localparam int          POS_LINK_PM       = 28;
   localparam int          POS_LOW_POWER     = 27;
   localparam int          POS_PM_REV        = 26;
   localparam int          POS_CLKPM         = 23;
   localparam logic [2:0]  PM_REV_OLD        = 3'h2;
   localparam logic [2:0]  PM_REV_NEW        = 3'h3;
   localparam int          CLK_MHZ           = 200;
   localparam int          RETRY_US_0        = 25;
   localparam int          RETRY_US_1        = 1000;
   localparam int          RETRY_US_2        = 25000;
   localparam int          RETRY_US_3        = 50000;
   localparam logic [23:0] RETRY_CYC_0       = 24'(RETRY_US_0 * CLK_MHZ);
   localparam logic [23:0] RETRY_CYC_1       = 24'(RETRY_US_1 * CLK_MHZ);
   localparam logic [23:0] RETRY_CYC_2       = 24'(RETRY_US_2 * CLK_MHZ);
   localparam logic [23:0] RETRY_CYC_3       = 24'(RETRY_US_3 * CLK_MHZ);
endpackage

// *** hw/ident_store.sv ***
// Shared storage for the two board identifier half-words.
// Assumes byte-enabled writes from the configuration decoder on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ident_store (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_resetn,
   input  wire logic        i_cfg_reset,
   // Write side
   input  wire logic        i_wr,
   input  wire logic [3:0]  i_be,
   input  wire logic [31:0] i_wdata,
   // Stored value
   output logic      [31:0] o_value
);
   logic [31:0] value_r;
   logic [31:0] value_nxt;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign value_nxt[g*8 +: 8] = (i_wr && i_be[g]) ? i_wdata[g*8 +: 8] : value_r[g*8 +: 8];
      end
   endgenerate
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         value_r <= bridge_ctl_pkg::ALIAS_RESET;
      end else if (i_cfg_reset) begin
         value_r <= bridge_ctl_pkg::ALIAS_RESET;
      end else begin
         value_r <= value_nxt;
      end
   end
   assign o_value = value_r;
endmodule
`default_nettype wire

// *** tb/bridge_general_ctl_test.sv ***
// Self-checking bench for the subsystem alias and upper general control bank.
// Assumes the bank is the only responder on the configuration strobes.
`timescale 1ns/1ps
`default_nettype none
module bridge_general_ctl_test;
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic        link_resetn = 1'b1;
   logic        global_reset_pin_n = 1'b1;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        start = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [3:0]  be = 4'h0;
   logic [3:0]  bsel;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, alias_m, rv, gm;
   logic        hit, expired, low_pwr, nsr;
   logic [1:0]  lpm, cpm;
   logic [2:0]  rev;
   int          mismatches = 0;
   int          comparisons = 0;
   int          seed = 63;
   int          n;

   bridge_general_ctl dut_u (
      .i_clock(clock), .i_resetn(resetn), .i_link_resetn(link_resetn),
      .i_global_reset_pin_n(global_reset_pin_n), .i_cfg_wr(wr), .i_cfg_rd(rd),
      .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata), .i_retry_start(start),
      .o_cfg_rdata(rdata), .o_cfg_hit(hit), .o_retry_expired(expired),
      .o_link_pm_default(lpm), .o_clock_pm_enable_field(cpm), .o_tx_low_power(low_pwr),
      .o_pm_revision_field(rev), .o_no_soft_reset(nsr)
   );

   initial forever #2.5 clock = ~clock;

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Drivers are entered just after a falling edge and leave one idle cycle,
   // so a following call never raises a strobe in the step that lowered it
   task automatic wr_cfg(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      addr = a;
      be = b;
      wdata = d;
      wr = 1'b1;
      @(negedge clock);
      wr = 1'b0;
      @(negedge clock);
   endtask

   task automatic rd_cfg(input logic [7:0] a, input logic [31:0] exp, input string what);
      addr = a;
      rd = 1'b1;
      #1;
      chk("hit", {31'h0000_0000, a inside {8'h44, 8'h46, 8'hD0, 8'hD4}}, {31'h0000_0000, hit});
      @(negedge clock);
      rd = 1'b0;
      chk(what, exp, rdata);
      @(negedge clock);
   endtask

   // Only bits 31:25 and 23 take writes; the rest keep their reset value
   function automatic logic [31:0] gen_exp(input logic [31:0] d);
      return (bridge_ctl_pkg::GEN_CTRL_RESET & ~32'hFE80_0000) | (d & 32'hFE80_0000);
   endfunction

   task automatic chk_gen(input logic [31:0] g);
      rd_cfg(8'hD4, g, "gen_ctrl");
      chk("link_pm", {30'h0000_0000, g[29:28]}, {30'h0000_0000, lpm});
      chk("clock_pm", {30'h0000_0000, {2{g[23]}}}, {30'h0000_0000, cpm});
      chk("low_power", {31'h0000_0000, g[27]}, {31'h0000_0000, low_pwr});
      chk("pm_rev", g[26] ? 32'h0000_0003 : 32'h0000_0002, {29'h0000_0000, rev});
      chk("no_soft_reset", {31'h0000_0000, g[26]}, {31'h0000_0000, nsr});
   endtask

   initial begin
      repeat (16) @(negedge clock);
      resetn = 1'b1;
      repeat (5) @(negedge clock);
      alias_m = bridge_ctl_pkg::ALIAS_RESET;
      chk_gen(bridge_ctl_pkg::GEN_CTRL_RESET);
      rd_cfg(8'hD0, alias_m, "alias");
      rd_cfg(8'h48, 32'h0000_0000, "unmapped");
      for (int i = 0; i < 12; i++) begin
         rv = $random(seed);
         bsel = (i == 0) ? 4'hF : rv[3:0];
         if (i == 1) rv = 32'hFFFF_FFFF;
         for (int b = 0; b < 4; b++) if (bsel[b]) alias_m[8*b +: 8] = rv[8*b +: 8];
         wr_cfg(8'hD0, bsel, rv);
         wr_cfg(8'h44, 4'hF, ~rv);
         wr_cfg(8'h46, 4'hF, ~rv);
         rd_cfg(8'hD0, alias_m, "alias");
         rd_cfg(8'h44, alias_m, "maker_ident");
         rd_cfg(8'h46, {16'h0000, alias_m[31:16]}, "product_ident");
         // Software keeps the reserved writable bit at zero
         gm = {rv[31:26] ^ {i[1:0], ~i[1:0], 2'h0}, 1'b0, rv[24:0]};
         wr_cfg(8'hD4, 4'hF, gm);
         chk_gen(gen_exp(gm));
      end
      // Shortest retry window only: the longer ones would dwarf the run
      wr_cfg(8'hD4, 4'hF, 32'h0000_0000);
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      n = 1;
      while (expired !== 1'b1 && n < 6000) begin
         @(negedge clock);
         n++;
      end
      chk("retry_window", 32'h0000_0001,
          {31'h0000_0000, n >= int'(bridge_ctl_pkg::RETRY_CYC_0) && n <= int'(bridge_ctl_pkg::RETRY_CYC_0) + 2});
      if (n >= 6000) end_of_test();
      @(negedge clock);
      chk("retry_pulse", 32'h0000_0000, {31'h0000_0000, expired});
      for (int k = 0; k < 3; k++) begin
         wr_cfg(8'hD4, 4'hF, 32'h5D80_0000);
         wr_cfg(8'hD0, 4'hF, $random(seed));
         if (k == 0) link_resetn = 1'b0;
         else if (k == 1) global_reset_pin_n = 1'b0;
         else resetn = 1'b0;
         repeat (4) @(negedge clock);
         wr_cfg(8'hD4, 4'hF, 32'hFDFF_FFFF);
         link_resetn = 1'b1;
         global_reset_pin_n = 1'b1;
         resetn = 1'b1;
         repeat (5) @(negedge clock);
         chk_gen(bridge_ctl_pkg::GEN_CTRL_RESET);
         rd_cfg(8'hD0, bridge_ctl_pkg::ALIAS_RESET, "alias_after_reset");
      end
      end_of_test();
   end
endmodule
`default_nettype wire
